// *** rtl/ebr_regs.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - control bit 8 enables receive buffered idle
// - bits 6:4 set refresh gating extension frames
// - control bit 3 resets transmit buffered path
// - control bit 1 enables transmit buffered idle
// - control bit 0 enables state-machine-ready mode
// - upper threshold is 16-bit, resets zero
// - lower threshold is 16-bit, resets zero
// - latency value bits 10:0, resets 0x47E
// - status bit 4 reports quick retrain capability
// - status bit 3 reports quick retrain agreed
// - bit 15 allows deleting sole idle column
// - bits 9 and 2 enable long messages
// - bits 8 and 1 enable timestamp codes
// - bits 7 and 0 select vendor header mode
module ebr_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic quick_retrain_agreed_in,
    output logic rx_buffered_idle_enable,
    output logic [2:0] refresh_gating_extension,
    output logic tx_buffered_idle_reset,
    output logic tx_latency_mode,
    output logic tx_buffered_idle_enable,
    output logic tx_state_machine_ready_enable,
    output logic [15:0] idle_threshold_upper,
    output logic [15:0] idle_threshold_lower,
    output logic [10:0] fixed_latency_value,
    output logic quick_retrain_capable,
    output logic quick_retrain_agreed,
    output logic sole_idle_column_delete_enable,
    output logic rx_long_message_enable,
    output logic rx_timestamp_code_enable,
    output logic rx_header_mode_enable,
    output logic tx_long_message_enable,
    output logic tx_timestamp_code_enable,
    output logic tx_header_mode_enable
);
    logic rx_en_q, rx_en_d;
    logic [2:0] ext_q, ext_d;
    logic tx_rst_q, tx_rst_d;
    logic lat_mode_q, lat_mode_d;
    logic tx_en_q, tx_en_d;
    logic sm_rdy_q, sm_rdy_d;
    logic [15:0] thr_hi_q, thr_hi_d;
    logic [15:0] thr_lo_q, thr_lo_d;
    logic [10:0] lat_q, lat_d;
    logic capable_q, capable_d;
    logic agreed_q, agreed_d;
    logic [15:0] hm_q, hm_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // writable bits of the header-mode register, built from the field positions
    function automatic logic [15:0] header_mask();
        logic [15:0] mask;
        mask = 16'h0000;
        mask[ebr_pkg::HM_DELETE_BIT] = 1'b1;
        mask[ebr_pkg::HM_RX_LONG_BIT] = 1'b1;
        mask[ebr_pkg::HM_RX_TS_BIT] = 1'b1;
        mask[ebr_pkg::HM_RX_MODE_BIT] = 1'b1;
        mask[ebr_pkg::HM_TX_LONG_BIT] = 1'b1;
        mask[ebr_pkg::HM_TX_TS_BIT] = 1'b1;
        mask[ebr_pkg::HM_TX_MODE_BIT] = 1'b1;
        return mask;
    endfunction

    // which register an access points at; anything else is a hole
    typedef enum {
        SEL_NONE,
        SEL_CONTROL,
        SEL_THR_HIGH,
        SEL_THR_LOW,
        SEL_LATENCY,
        SEL_RETRAIN,
        SEL_HEADER
    } ebr_sel_e;

    // one decode for both write and read, so a hole can never be
    // writable at one address and read back at another
    function automatic ebr_sel_e decode_addr(input logic [15:0] addr);
        ebr_sel_e sel;
        sel = SEL_NONE;
        if (addr == ebr_pkg::ADDR_BUFFER_CONTROL) begin
            sel = SEL_CONTROL;
        end else if (addr == ebr_pkg::ADDR_THRESHOLD_HIGH) begin
            sel = SEL_THR_HIGH;
        end else if (addr == ebr_pkg::ADDR_THRESHOLD_LOW) begin
            sel = SEL_THR_LOW;
        end else if (addr == ebr_pkg::ADDR_FIXED_LATENCY) begin
            sel = SEL_LATENCY;
        end else if (addr == ebr_pkg::ADDR_RETRAIN_STATUS) begin
            sel = SEL_RETRAIN;
        end else if (addr == ebr_pkg::ADDR_HEADER_MODE) begin
            sel = SEL_HEADER;
        end
        return sel;
    endfunction

    // control word as software reads it; reserved bits read zero
    function automatic logic [15:0] pack_control(
        input logic rx_en,
        input logic [2:0] ext,
        input logic tx_rst,
        input logic lat_mode,
        input logic tx_en,
        input logic sm_rdy
    );
        logic [15:0] word;
        word = 16'h0000;
        word[ebr_pkg::CTL_RX_ENABLE_BIT] = rx_en;
        word[ebr_pkg::CTL_EXT_LSB +: ebr_pkg::CTL_EXT_W] = ext;
        word[ebr_pkg::CTL_TX_RESET_BIT] = tx_rst;
        word[ebr_pkg::CTL_LAT_MODE_BIT] = lat_mode;
        word[ebr_pkg::CTL_TX_ENABLE_BIT] = tx_en;
        word[ebr_pkg::CTL_SM_READY_BIT] = sm_rdy;
        return word;
    endfunction

    // decoded access and per-register write strobes
    ebr_sel_e acc_sel;
    logic wr_control;
    logic wr_thr_high;
    logic wr_thr_low;
    logic wr_latency;
    logic wr_retrain;
    logic wr_header;

    // write strobes; an access to a hole raises none of them
    // a read and a write may stand in one cycle; the read sees the old word
    always_comb begin
        acc_sel = decode_addr(reg_addr);
        wr_control = reg_write && (acc_sel == SEL_CONTROL);
        wr_thr_high = reg_write && (acc_sel == SEL_THR_HIGH);
        wr_thr_low = reg_write && (acc_sel == SEL_THR_LOW);
        wr_latency = reg_write && (acc_sel == SEL_LATENCY);
        wr_retrain = reg_write && (acc_sel == SEL_RETRAIN);
        wr_header = reg_write && (acc_sel == SEL_HEADER);
    end

    // control next values; a write replaces every field at once,
    // so software has to read-modify-write to keep fields it does
    // not mean to change
    always_comb begin
        rx_en_d = rx_en_q;
        ext_d = ext_q;
        tx_rst_d = tx_rst_q;
        lat_mode_d = lat_mode_q;
        tx_en_d = tx_en_q;
        sm_rdy_d = sm_rdy_q;
        if (wr_control) begin
            rx_en_d = reg_wdata[ebr_pkg::CTL_RX_ENABLE_BIT];
            ext_d = reg_wdata[ebr_pkg::CTL_EXT_LSB +: ebr_pkg::CTL_EXT_W];
            // held as written, not self-clearing; the datapath flushes while it is 1
            tx_rst_d = reg_wdata[ebr_pkg::CTL_TX_RESET_BIT];
            // a reserved 0 is stored as written; only 1 is a defined mode
            lat_mode_d = reg_wdata[ebr_pkg::CTL_LAT_MODE_BIT];
            tx_en_d = reg_wdata[ebr_pkg::CTL_TX_ENABLE_BIT];
            sm_rdy_d = reg_wdata[ebr_pkg::CTL_SM_READY_BIT];
        end
    end

    // control registers, synchronous reset
    // the extension field is the only one not reset to zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_en_q <= 1'b0;
            ext_q <= ebr_pkg::CTL_EXT_RESET;
            tx_rst_q <= 1'b0;
            lat_mode_q <= 1'b0;
            tx_en_q <= 1'b0;
            sm_rdy_q <= 1'b0;
        end else begin
            rx_en_q <= rx_en_d;
            ext_q <= ext_d;
            tx_rst_q <= tx_rst_d;
            lat_mode_q <= lat_mode_d;
            tx_en_q <= tx_en_d;
            sm_rdy_q <= sm_rdy_d;
        end
    end

    // threshold next values; both are plain 16-bit words
    // the pair is only stored here; keeping them ordered is up to software
    always_comb begin
        thr_hi_d = thr_hi_q;
        thr_lo_d = thr_lo_q;
        if (wr_thr_high) begin
            thr_hi_d = reg_wdata;
        end
        if (wr_thr_low) begin
            thr_lo_d = reg_wdata;
        end
    end

    // threshold registers
    always_ff @(posedge clk) begin
        if (reset) begin
            thr_hi_q <= ebr_pkg::THRESHOLD_RESET;
            thr_lo_q <= ebr_pkg::THRESHOLD_RESET;
        end else begin
            thr_hi_q <= thr_hi_d;
            thr_lo_q <= thr_lo_d;
        end
    end

    // latency next value; upper five bits of the word are dropped
    // so they always read back as zero
    always_comb begin
        lat_d = lat_q;
        if (wr_latency) begin
            lat_d = reg_wdata[ebr_pkg::LAT_W-1:0];
        end
    end

    // latency register
    // the nonzero reset gives a usable latency before software acts
    always_ff @(posedge clk) begin
        if (reset) begin
            lat_q <= ebr_pkg::LAT_RESET;
        end else begin
            lat_q <= lat_d;
        end
    end

    // retrain status next values
    // capability is plain read-write, with nothing else driving it
    always_comb begin
        capable_d = capable_q;
        // negotiation result follows the link in every cycle without a status write
        agreed_d = quick_retrain_agreed_in;
        // a software write wins for one cycle, then the link result returns
        if (wr_retrain) begin
            capable_d = reg_wdata[ebr_pkg::FR_CAPABLE_BIT];
            agreed_d = reg_wdata[ebr_pkg::FR_AGREED_BIT];
        end
    end

    // retrain status registers
    // capability resets to 1, as the link side supports quick retrain
    always_ff @(posedge clk) begin
        if (reset) begin
            capable_q <= ebr_pkg::FR_CAPABLE_RESET;
            agreed_q <= 1'b0;
        end else begin
            capable_q <= capable_d;
            agreed_q <= agreed_d;
        end
    end

    // header-mode next value; reserved bits are masked off so they read zero
    // each path has its own three enables; none depends on another
    always_comb begin
        hm_d = hm_q;
        if (wr_header) begin
            hm_d = reg_wdata & header_mask();
        end
    end

    // header-mode register
    // every enable resets off, so the coding sublayer starts in plain mode
    always_ff @(posedge clk) begin
        if (reset) begin
            hm_q <= 16'h0000;
        end else begin
            hm_q <= hm_d;
        end
    end

    // read port; the word reflects state before a same-cycle write
    // the shared decode means a hole reads zero and ignores writes
    always_comb begin
        rvalid_d = reg_read;
        rdata_d = 16'h0000;
        // reserved bits read zero; software ignores them anyway
        if (reg_read) begin
            if (acc_sel == SEL_CONTROL) begin
                rdata_d = pack_control(rx_en_q, ext_q, tx_rst_q,
                    lat_mode_q, tx_en_q, sm_rdy_q);
            end else if (acc_sel == SEL_THR_HIGH) begin
                rdata_d = thr_hi_q;
            end else if (acc_sel == SEL_THR_LOW) begin
                rdata_d = thr_lo_q;
            end else if (acc_sel == SEL_LATENCY) begin
                rdata_d[ebr_pkg::LAT_W-1:0] = lat_q;
            end else if (acc_sel == SEL_RETRAIN) begin
                rdata_d[ebr_pkg::FR_CAPABLE_BIT] = capable_q;
                rdata_d[ebr_pkg::FR_AGREED_BIT] = agreed_q;
            end else if (acc_sel == SEL_HEADER) begin
                rdata_d = hm_q;
            end
        end
    end

    // read port registers; data is zero whenever no answer stands
    // the answer is a one-cycle pulse with no wait state
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign rx_buffered_idle_enable = rx_en_q;
    assign refresh_gating_extension = ext_q;
    assign tx_buffered_idle_reset = tx_rst_q;
    assign tx_latency_mode = lat_mode_q;
    assign tx_buffered_idle_enable = tx_en_q;
    assign tx_state_machine_ready_enable = sm_rdy_q;
    assign idle_threshold_upper = thr_hi_q;
    assign idle_threshold_lower = thr_lo_q;
    assign fixed_latency_value = lat_q;
    assign quick_retrain_capable = capable_q;
    assign quick_retrain_agreed = agreed_q;
    assign sole_idle_column_delete_enable = hm_q[ebr_pkg::HM_DELETE_BIT];
    assign rx_long_message_enable = hm_q[ebr_pkg::HM_RX_LONG_BIT];
    assign rx_timestamp_code_enable = hm_q[ebr_pkg::HM_RX_TS_BIT];
    assign rx_header_mode_enable = hm_q[ebr_pkg::HM_RX_MODE_BIT];
    assign tx_long_message_enable = hm_q[ebr_pkg::HM_TX_LONG_BIT];
    assign tx_timestamp_code_enable = hm_q[ebr_pkg::HM_TX_TS_BIT];
    assign tx_header_mode_enable = hm_q[ebr_pkg::HM_TX_MODE_BIT];
endmodule // ebr_regs

// *** rtl/ebr_pkg.sv ***
package ebr_pkg;
    // register addresses within device 1
    localparam logic [15:0] ADDR_BUFFER_CONTROL = 16'hA88A;
    localparam logic [15:0] ADDR_THRESHOLD_HIGH = 16'hA88C;
    localparam logic [15:0] ADDR_THRESHOLD_LOW = 16'hA88D;
    localparam logic [15:0] ADDR_FIXED_LATENCY = 16'hA88E;
    localparam logic [15:0] ADDR_RETRAIN_STATUS = 16'hA92B;
    localparam logic [15:0] ADDR_HEADER_MODE = 16'hA939;

    // control register fields
    localparam int CTL_RX_ENABLE_BIT = 8;
    localparam int CTL_EXT_LSB = 4;
    localparam int CTL_EXT_W = 3;
    localparam int CTL_TX_RESET_BIT = 3;
    localparam int CTL_LAT_MODE_BIT = 2;
    localparam int CTL_TX_ENABLE_BIT = 1;
    localparam int CTL_SM_READY_BIT = 0;
    localparam logic [2:0] CTL_EXT_RESET = 3'h1;

    // latency register field
    localparam int LAT_W = 11;
    localparam logic [10:0] LAT_RESET = 11'h47E;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;

    // fast retrain status fields
    localparam int FR_CAPABLE_BIT = 4;
    localparam int FR_AGREED_BIT = 3;
    localparam logic FR_CAPABLE_RESET = 1'b1;

    // header mode register fields
    localparam int HM_DELETE_BIT = 15;
    localparam int HM_RX_LONG_BIT = 9;
    localparam int HM_RX_TS_BIT = 8;
    localparam int HM_RX_MODE_BIT = 7;
    localparam int HM_TX_LONG_BIT = 2;
    localparam int HM_TX_TS_BIT = 1;
    localparam int HM_TX_MODE_BIT = 0;
endpackage

// *** testbench/ebr_regs_chk.sv ***
`timescale 1ns/100ps
module ebr_regs_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic quick_retrain_agreed_in,
    input wire logic rx_buffered_idle_enable,
    input wire logic [2:0] refresh_gating_extension,
    input wire logic [15:0] idle_threshold_upper,
    input wire logic [10:0] fixed_latency_value,
    input wire logic quick_retrain_capable,
    input wire logic quick_retrain_agreed,
    input wire logic sole_idle_column_delete_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // write strobes decoded for the control and retrain status registers
    wire logic wr_ctl = reg_write && (reg_addr == 16'hA88A);
    wire logic wr_frs = reg_write && (reg_addr == 16'hA92B);

    chk_rx_enable: assert property (wr_ctl |=> rx_buffered_idle_enable == $past(reg_wdata[8]))
        else $error("rx enable not taken from write");
    chk_ext_field: assert property (wr_ctl |=> refresh_gating_extension == $past(reg_wdata[6:4]))
        else $error("gating extension not taken from write");
    chk_upper_thr: assert property (reg_write && reg_addr == 16'hA88C |=>
        idle_threshold_upper == $past(reg_wdata)) else $error("upper threshold wrong");
    chk_latency_val: assert property (reg_write && reg_addr == 16'hA88E |=>
        fixed_latency_value == $past(reg_wdata[10:0])) else $error("latency wrong");
    chk_capable_bit: assert property (wr_frs |=> quick_retrain_capable == $past(reg_wdata[4]))
        else $error("capable bit wrong");
    chk_agreed_follow: assert property (!wr_frs |=> quick_retrain_agreed == $past(quick_retrain_agreed_in))
        else $error("agreed bit does not follow link result");
    chk_delete_en: assert property (reg_write && reg_addr == 16'hA939 |=>
        sole_idle_column_delete_enable == $past(reg_wdata[15])) else $error("delete bit wrong");
    chk_ctl_reserved: assert property (reg_read && reg_addr == 16'hA88A |=>
        reg_rdata[15:9] == 7'h00 && !reg_rdata[7]) else $error("reserved bits not zero");
endmodule // ebr_regs_chk

bind ebr_regs ebr_regs_chk u_chk (.clk(clk), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .quick_retrain_agreed_in(quick_retrain_agreed_in),
    .rx_buffered_idle_enable(rx_buffered_idle_enable),
    .refresh_gating_extension(refresh_gating_extension),
    .idle_threshold_upper(idle_threshold_upper), .fixed_latency_value(fixed_latency_value),
    .quick_retrain_capable(quick_retrain_capable), .quick_retrain_agreed(quick_retrain_agreed),
    .sole_idle_column_delete_enable(sole_idle_column_delete_enable));

// *** testbench/ebr_regs_tb.sv ***
`timescale 1ns/100ps
module ebr_regs_tb;
    logic clk, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, quick_retrain_agreed_in = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
    logic [15:0] idle_threshold_upper, idle_threshold_lower;
    logic [2:0] refresh_gating_extension;
    logic [10:0] fixed_latency_value;
    logic reg_rvalid, rx_buffered_idle_enable, tx_buffered_idle_reset, tx_latency_mode;
    logic tx_buffered_idle_enable, tx_state_machine_ready_enable, quick_retrain_capable;
    logic quick_retrain_agreed, sole_idle_column_delete_enable, rx_long_message_enable;
    logic rx_timestamp_code_enable, rx_header_mode_enable, tx_long_message_enable;
    logic tx_timestamp_code_enable, tx_header_mode_enable;
    // reset table, last entry is an unmapped hole that must read zero
    logic [15:0] addrs [7] = '{16'hA88A, 16'hA88C, 16'hA88D, 16'hA88E, 16'hA92B, 16'hA939, 16'hA88B};
    logic [15:0] rst_exp [7] = '{16'h0010, 16'h0000, 16'h0000, 16'h047E, 16'h0010, 16'h0000, 16'h0000};
    int bad_count = 0;
    int total_checks = 0;

    ebr_regs DUT (
        .clk(clk),
        .reset(reset),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .quick_retrain_agreed_in(quick_retrain_agreed_in),
        .rx_buffered_idle_enable(rx_buffered_idle_enable),
        .refresh_gating_extension(refresh_gating_extension),
        .tx_buffered_idle_reset(tx_buffered_idle_reset),
        .tx_latency_mode(tx_latency_mode),
        .tx_buffered_idle_enable(tx_buffered_idle_enable),
        .tx_state_machine_ready_enable(tx_state_machine_ready_enable),
        .idle_threshold_upper(idle_threshold_upper),
        .idle_threshold_lower(idle_threshold_lower),
        .fixed_latency_value(fixed_latency_value),
        .quick_retrain_capable(quick_retrain_capable),
        .quick_retrain_agreed(quick_retrain_agreed),
        .sole_idle_column_delete_enable(sole_idle_column_delete_enable),
        .rx_long_message_enable(rx_long_message_enable),
        .rx_timestamp_code_enable(rx_timestamp_code_enable),
        .rx_header_mode_enable(rx_header_mode_enable),
        .tx_long_message_enable(tx_long_message_enable),
        .tx_timestamp_code_enable(tx_timestamp_code_enable),
        .tx_header_mode_enable(tx_header_mode_enable)
    );

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle strobes; the trailing #1 lets the registered answer settle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk({reg_rvalid, 15'h0000}, 16'h8000);
        chk(reg_rdata, exp);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hang ends the run as a failure
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    initial begin
        for (int r = 0; r < 2; r++) begin
            // mid-run reset is raised on an edge like every other input
            @(posedge clk);
            reset <= 1'b1;
            repeat (4) @(posedge clk);
            reset <= 1'b0;
            for (int i = 0; i < 7; i++) rd(addrs[i], rst_exp[i]);
            wr(16'hA88A, 16'hFFFF);
            chk({7'h00, rx_buffered_idle_enable, 1'b0, refresh_gating_extension, tx_buffered_idle_reset,
                tx_latency_mode, tx_buffered_idle_enable, tx_state_machine_ready_enable}, 16'h017F);
            rd(16'hA88A, 16'h017F);
            wr(16'hA88A, 16'h0000);
            chk({7'h00, rx_buffered_idle_enable, 1'b0, refresh_gating_extension, tx_buffered_idle_reset,
                tx_latency_mode, tx_buffered_idle_enable, tx_state_machine_ready_enable}, 16'h0000);
            wr(16'hA88C, 16'hA5C3);
            wr(16'hA88D, 16'h3C5A);
            wr(16'hA88E, 16'hFFFF);
            chk(idle_threshold_upper, 16'hA5C3);
            chk(idle_threshold_lower, 16'h3C5A);
            rd(16'hA88E, 16'h07FF);
            wr(16'hA939, 16'hFFFF);
            chk({sole_idle_column_delete_enable, 5'h00, rx_long_message_enable, rx_timestamp_code_enable,
                rx_header_mode_enable, 4'h0, tx_long_message_enable, tx_timestamp_code_enable,
                tx_header_mode_enable}, 16'h8387);
            rd(16'hA939, 16'h8387);
            @(posedge clk);
            quick_retrain_agreed_in <= 1'b1;
            rd(16'hA92B, 16'h0018);
            wr(16'hA92B, 16'h0000);
            chk({14'h0000, quick_retrain_capable, quick_retrain_agreed}, 16'h0000);
            rd(16'hA92B, 16'h0008);
            chk({15'h0000, quick_retrain_agreed}, 16'h0001);
            @(posedge clk);
            quick_retrain_agreed_in <= 1'b0;
            wr(16'hA88B, 16'hFFFF);
            rd(16'hA88A, 16'h0000);
        end
        stop_test();
    end
endmodule // ebr_regs_tb
